// [rtl/can_pkg.sv]
// constants, types and carriers for the can tx, filter and flag block
// Operation
// - three tx buffers, 13-byte image each
// - each buffer has 8-bit rank field
// - sent buffer sets empty flag, tx irq
// - lowest rank value transmits first
// - reselect buffer at every arbitration attempt
// - abort unsent buffer: ack, empty, irq
// - four pattern and four mask bytes
// - accept sets rx full, lowest hit index
// - single mode: one 32-bit filter
// - dual mode: two 16-bit filters
// - quad mode: four 8-bit filters
// - closed mode never accepts a message
// - four irq lines, eleven masked sources
// - accepted frame sets rx full, rx irq
// - wakeup only with sleep ack and enable
// - warning flags at error count 96
// - passive flags above error count 127
// - bus-off flag above tx count 255
// - overrun sets flag, error irq
// - write one clears, condition holds flag
// - copy background only while rx full clear
// - both buffers full: drop, flag overrun
package can_pkg;
  localparam int          NBUF      = 3;
  localparam int          IMG_W     = 104;
  localparam int          IMG_PAD   = 24;
  localparam int          ID_W      = 32;
  localparam int          WORD_W    = 32;
  localparam int          BYTE_W    = 8;
  localparam int          HALF_W    = 16;
  localparam int          NSEC      = 4;
  localparam int          BUF_LSB   = 4;
  localparam int          WORD_LSB  = 2;
  localparam logic [1:0]  LAST_WORD = 2'h3;
  localparam logic [1:0]  NO_BUF    = 2'h3;
  localparam logic [31:0] LAST_MASK = 32'h0000_00ff;
  localparam logic [31:0] ALL_ONES  = 32'hffff_ffff;
  localparam logic [2:0]  BUF0      = 3'h1;
  localparam logic [2:0]  TXE_RST   = 3'h7;
  localparam logic [1:0]  SYNC_RST  = 2'h3;
  // register byte offsets
  localparam logic [11:0] CTRL_OFS  = 12'h000;
  localparam logic [11:0] RXFLG_OFS = 12'h004;
  localparam logic [11:0] RXIE_OFS  = 12'h008;
  localparam logic [11:0] TXFLG_OFS = 12'h00c;
  localparam logic [11:0] TXCTL_OFS = 12'h010;
  localparam logic [11:0] PAT_OFS   = 12'h014;
  localparam logic [11:0] MSK_OFS   = 12'h018;
  localparam logic [11:0] HIT_OFS   = 12'h01c;
  localparam logic [11:0] RANK_OFS  = 12'h020;
  localparam logic [11:0] ERRC_OFS  = 12'h024;
  localparam logic [11:0] TXB_BASE  = 12'h040;
  localparam logic [11:0] TXB_MASK  = 12'hfc0;
  localparam logic [11:0] RXB_BASE  = 12'h080;
  localparam logic [11:0] RXB_MASK  = 12'hff0;
  // rx flag and enable bit positions
  localparam int FLG_WAKE = 7;
  localparam int FLG_RXW  = 6;
  localparam int FLG_TXW  = 5;
  localparam int FLG_RXP  = 4;
  localparam int FLG_TXP  = 3;
  localparam int FLG_BOFF = 2;
  localparam int FLG_OVR  = 1;
  localparam int FLG_RXF  = 0;
  localparam int ERR_HI   = 6;
  localparam int ERR_LO   = 1;
  // error counter limits
  localparam logic [7:0]  RWARN   = 8'h60;
  localparam logic [7:0]  RPASS   = 8'h7f;
  localparam logic [7:0]  REC_MAX = 8'hff;
  localparam logic [8:0]  TWARN   = 9'h060;
  localparam logic [8:0]  TPASS   = 9'h07f;
  localparam logic [8:0]  TBOFF   = 9'h0ff;
  localparam logic [8:0]  TEC_INC = 9'h008;
  localparam logic [8:0]  TEC_DEC = 9'h001;
  localparam logic [7:0]  REC_DEC = 8'h01;

  typedef enum logic [1:0] {
    FM_SINGLE = 2'h0,
    FM_DUAL   = 2'h1,
    FM_QUAD   = 2'h3,
    FM_CLOSED = 2'h2
  } filt_mode_e;

  typedef enum logic [1:0] {
    TX_IDLE   = 2'h0,
    TX_ACTIVE = 2'h1
  } tx_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic             arbStart;
    logic             txDone;
    logic             txFail;
    logic             rxValid;
    logic             rxErr;
    logic             busOffRecover;
    logic [ID_W-1:0]  rxId;
    logic [IMG_W-1:0] rxImage;
  } eng_evt_s;

  typedef struct packed {
    logic             txPending;
    logic             txActive;
    logic [1:0]       txSel;
    logic [IMG_W-1:0] txImage;
  } tx_out_s;

  typedef struct packed {
    logic wake;
    logic err;
    logic rx;
    logic tx;
  } irq_s;
endpackage

// [rtl/can_tx_rank_pick.sv]
// lowest-rank selection among scheduled transmit buffers
`timescale 1ns/1ps
module can_tx_rank_pick (
  input  wire logic [can_pkg::NBUF-1:0]      cand,
  input  wire logic [can_pkg::NBUF-1:0][7:0] rank,
  output logic                               found,
  output logic [1:0]                         idx
);
  import can_pkg::*;

  // strict compare keeps the lower buffer number on equal ranks
  always_comb begin
    found = 1'b0;
    idx   = 2'h0;
    for (int i = 0; i < NBUF; i++) begin
      if (cand[i] && (!found || rank[i] < rank[idx])) begin
        found = 1'b1;
        idx   = 2'(i);
      end
    end
  end
endmodule

// [rtl/can_accept_filter.sv]
// identifier acceptance filter with four section modes
`timescale 1ns/1ps
module can_accept_filter (
  input  wire logic [can_pkg::ID_W-1:0] rxId,
  input  wire logic [can_pkg::ID_W-1:0] pattern,
  input  wire logic [can_pkg::ID_W-1:0] mask,
  input  can_pkg::filt_mode_e           mode,
  output logic                          hit,
  output logic [1:0]                    hitIdx
);
  import can_pkg::*;

  logic [NSEC-1:0] quadHit;
  logic [1:0]      dualHit;
  logic            singleHit;

  // a set mask bit makes that pattern bit a don't care
  assign singleHit = &(~(rxId ^ pattern) | mask);

  genvar g;
  generate
    for (g = 0; g < NSEC; g++) begin : g_sec
      localparam int QH = ID_W - 1 - g * BYTE_W;
      assign quadHit[g] = &(~(rxId[ID_W-1 -: BYTE_W]
                              ^ pattern[QH -: BYTE_W])
                            | mask[QH -: BYTE_W]);
      if (g < 2) begin : g_dual
        localparam int DH = ID_W - 1 - g * HALF_W;
        assign dualHit[g] = &(~(rxId[ID_W-1 -: HALF_W]
                                ^ pattern[DH -: HALF_W])
                              | mask[DH -: HALF_W]);
      end
    end
  endgenerate

  // lowest matching section is reported
  always_comb begin
    hit    = 1'b0;
    hitIdx = 2'h0;
    case (mode)
      FM_SINGLE: begin
        hit = singleHit;
      end
      FM_DUAL: begin
        hit    = |dualHit;
        hitIdx = dualHit[0] ? 2'h0 : 2'h1;
      end
      FM_QUAD: begin
        hit    = |quadHit;
        hitIdx = quadHit[0] ? 2'h0 : quadHit[1] ? 2'h1 :
                 quadHit[2] ? 2'h2 : 2'h3;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end
endmodule

// [rtl/can_tx_sched_filter_irq.sv]
// can tx buffers, rank scheduling, acceptance and flag block
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module can_tx_sched_filter_irq (
  input  wire logic        clk,
  input  wire logic        reset,
  input  can_pkg::apb_req_s apbReq,
  output can_pkg::apb_rsp_s apbRsp,
  input  can_pkg::eng_evt_s engEvt,
  input  wire logic        rxPin,
  input  wire logic        sleepAck,
  output can_pkg::tx_out_s txOut,
  output can_pkg::irq_s    irq,
  output logic             errPassive,
  output logic             busOffState
);
  import can_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                             rdy;
    logic [WORD_W-1:0]                rdata;
    logic                             slverr;
    logic [1:0]                       sync;
    logic [7:0]                       flags;
    logic [7:0]                       rxIe;
    filt_mode_e                       mode;
    logic [ID_W-1:0]                  pat;
    logic [ID_W-1:0]                  msk;
    logic [1:0]                       hit;
    logic [NBUF-1:0]                  txEmpty;
    logic [NBUF-1:0]                  abortReq;
    logic [NBUF-1:0]                  abortAck;
    logic [NBUF-1:0]                  txIe;
    logic [NBUF-1:0][7:0]             rank;
    logic [NBUF-1:0][4*WORD_W-1:0]    txBuf;
    logic [4*WORD_W-1:0]              rxBuf;
    logic [IMG_W-1:0]                 bgBuf;
    logic                             bgPend;
    logic [1:0]                       bgHit;
    tx_state_e                        txState;
    logic [1:0]                       txSel;
    logic [IMG_W-1:0]                 txImg;
    logic [7:0]                       rec;
    logic [8:0]                       tec;
  } state_s;

  state_s            st_q;
  state_s            st_d;
  logic              fHit;
  logic [1:0]        fIdx;
  logic              sFound;
  logic [1:0]        sIdx;
  logic [NBUF-1:0]   cand;
  logic [NBUF-1:0]   busyMask;
  logic [NBUF-1:0]   grant;
  logic [NBUF-1:0]   sched;
  logic [7:0]        setF;
  logic [7:0]        clrF;
  logic [WORD_W-1:0] rdMux;
  logic [WORD_W-1:0] wMask;
  logic              mapped;
  logic              acc;
  logic              wrEn;
  logic              isTxb;
  logic              isRxb;
  logic [1:0]        bufIdx;
  logic [1:0]        wordIdx;
  logic              busOff;
  logic              accepted;
  logic              copyBg;
  logic              direct;
  logic              toBg;
  logic              ovrEvt;
  logic              rankOk;

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  can_accept_filter u_filter (
    .rxId    (engEvt.rxId),
    .pattern (st_q.pat),
    .mask    (st_q.msk),
    .mode    (st_q.mode),
    .hit     (fHit),
    .hitIdx  (fIdx)
  );

  can_tx_rank_pick u_pick (
    .cand  (cand),
    .rank  (st_q.rank),
    .found (sFound),
    .idx   (sIdx)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // one wait state: read data is registered before pready
  assign acc     = apbReq.psel & apbReq.penable;
  assign wrEn    = acc & st_q.rdy & apbReq.pwrite & mapped;
  assign bufIdx  = apbReq.paddr[BUF_LSB +: 2];
  assign wordIdx = apbReq.paddr[WORD_LSB +: 2];
  assign isTxb   = ((apbReq.paddr & TXB_MASK) == TXB_BASE)
                   && (bufIdx != NO_BUF);
  assign isRxb   = (apbReq.paddr & RXB_MASK) == RXB_BASE;
  assign wMask   = (wordIdx == LAST_WORD) ? LAST_MASK : ALL_ONES;

  // flag clears are write-one; zeros leave other flags alone
  assign clrF  = (wrEn && apbReq.paddr == RXFLG_OFS) ?
                 apbReq.pwdata[7:0] : 8'h00;
  assign sched = (wrEn && apbReq.paddr == TXFLG_OFS) ?
                 apbReq.pwdata[NBUF-1:0] & st_q.txEmpty : '0;

  // read mux, unmapped addresses answer with pslverr
  always_comb begin
    rdMux  = '0;
    mapped = 1'b1;
    case (apbReq.paddr)
      CTRL_OFS:  rdMux = 32'(st_q.mode);
      RXFLG_OFS: rdMux = 32'(st_q.flags);
      RXIE_OFS:  rdMux = 32'(st_q.rxIe);
      TXFLG_OFS: rdMux = 32'({st_q.abortAck, 1'b0, st_q.txEmpty});
      TXCTL_OFS: rdMux = 32'({st_q.txIe, 1'b0, st_q.abortReq});
      PAT_OFS:   rdMux = st_q.pat;
      MSK_OFS:   rdMux = st_q.msk;
      HIT_OFS:   rdMux = 32'(st_q.hit);
      RANK_OFS:  rdMux = 32'(st_q.rank);
      ERRC_OFS:  rdMux = 32'({st_q.tec, st_q.rec});
      default: begin
        if (isTxb) begin
          rdMux = st_q.txBuf[bufIdx][WORD_W*wordIdx +: WORD_W];
        end else if (isRxb) begin
          rdMux = st_q.rxBuf[WORD_W*wordIdx +: WORD_W];
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // tx and rx steering terms
  // ----------------------------------------------------------------
  // buffers with a pending abort are kept out of arbitration
  assign busOff   = st_q.tec > TBOFF;
  assign cand     = ~st_q.txEmpty & ~st_q.abortReq & {NBUF{~busOff}};
  assign busyMask = (st_q.txState == TX_ACTIVE) ? BUF0 << st_q.txSel
                                                : '0;
  // no abort is granted during sleep or for the frame on the wire
  assign grant    = st_q.abortReq & ~st_q.txEmpty & ~busyMask
                    & {NBUF{~sleepAck}};

  // background slot drains only into an empty host buffer
  assign copyBg   = st_q.bgPend & ~st_q.flags[FLG_RXF]
                    & ~sleepAck;
  assign accepted = engEvt.rxValid & fHit;
  assign direct   = accepted & ~st_q.flags[FLG_RXF] & ~st_q.bgPend;
  assign toBg     = accepted & ~direct & (~st_q.bgPend | copyBg);
  assign ovrEvt   = accepted & ~direct & ~toBg;

  // hardware set terms, held while the cause stays
  assign setF = {sleepAck & st_q.rxIe[FLG_WAKE] & ~st_q.sync[1],
                 st_q.rec >= RWARN,
                 st_q.tec >= TWARN,
                 st_q.rec > RPASS,
                 st_q.tec > TPASS,
                 busOff,
                 ovrEvt,
                 copyBg | direct};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    st_d.sync = {st_q.sync[0], rxPin};
    st_d.rdy  = acc & ~st_q.rdy;
    if (acc && !st_q.rdy) begin
      st_d.rdata  = rdMux;
      st_d.slverr = ~mapped;
    end
    // host register writes
    if (wrEn) begin
      case (apbReq.paddr)
        CTRL_OFS:  st_d.mode = filt_mode_e'(apbReq.pwdata[1:0]);
        RXIE_OFS:  st_d.rxIe = apbReq.pwdata[7:0];
        TXCTL_OFS: begin
          st_d.abortReq = st_q.abortReq | apbReq.pwdata[NBUF-1:0];
          st_d.txIe     = apbReq.pwdata[NBUF+1 +: NBUF];
        end
        PAT_OFS:   st_d.pat = apbReq.pwdata;
        MSK_OFS:   st_d.msk = apbReq.pwdata;
        RANK_OFS:  st_d.rank = apbReq.pwdata[NBUF*8-1:0];
        default: begin
          if (isTxb) begin
            st_d.txBuf[bufIdx][WORD_W*wordIdx +: WORD_W] =
              apbReq.pwdata & wMask;
          end
        end
      endcase
    end
    // flags: set wins over a same-cycle clear
    st_d.flags = (st_q.flags & ~clrF) | setF;
    // scheduling, then hardware releases of buffers
    st_d.txEmpty  = (st_q.txEmpty & ~sched) | grant;
    st_d.abortAck = (st_q.abortAck & ~sched) | grant;
    st_d.abortReq = st_d.abortReq & ~st_q.txEmpty & ~grant;
    case (st_q.txState)
      TX_IDLE: begin
        if (engEvt.arbStart && sFound) begin
          st_d.txState = TX_ACTIVE;
          st_d.txSel   = sIdx;
          st_d.txImg   = st_q.txBuf[sIdx][IMG_W-1:0];
        end
      end
      TX_ACTIVE: begin
        if (engEvt.txDone) begin
          st_d.txEmpty[st_q.txSel]  = 1'b1;
          st_d.abortAck[st_q.txSel] = 1'b0;
          st_d.abortReq[st_q.txSel] = 1'b0;
          st_d.txState              = TX_IDLE;
        end else if (engEvt.txFail) begin
          st_d.txState = TX_IDLE;
        end
      end
      default: begin
        st_d.txState = TX_IDLE;
      end
    endcase
    // fault confinement counters; tec does not count up while bus-off
    if (engEvt.busOffRecover && busOff) begin
      st_d.tec = '0;
      st_d.rec = '0;
    end else begin
      if (st_q.txState == TX_ACTIVE && engEvt.txFail && !busOff) begin
        st_d.tec = st_q.tec + TEC_INC;
      end else if (engEvt.txDone && st_q.tec != '0) begin
        st_d.tec = st_q.tec - TEC_DEC;
      end
      if (engEvt.rxErr && st_q.rec != REC_MAX) begin
        st_d.rec = st_q.rec + REC_DEC;
      end else if (engEvt.rxValid && st_q.rec != '0) begin
        st_d.rec = st_q.rec - REC_DEC;
      end
    end
    // receive path into host and background slots
    if (copyBg) begin
      st_d.rxBuf  = {{IMG_PAD{1'b0}}, st_q.bgBuf};
      st_d.hit    = st_q.bgHit;
      st_d.bgPend = 1'b0;
    end
    if (direct) begin
      st_d.rxBuf = {{IMG_PAD{1'b0}}, engEvt.rxImage};
      st_d.hit   = fIdx;
    end
    if (toBg) begin
      st_d.bgBuf  = engEvt.rxImage;
      st_d.bgHit  = fIdx;
      st_d.bgPend = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q         <= '0;
      st_q.txEmpty <= TXE_RST;
      st_q.sync    <= SYNC_RST; // recessive, so no false wake after reset
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign apbRsp.prdata  = st_q.rdata;
  assign apbRsp.pready  = st_q.rdy;
  assign apbRsp.pslverr = st_q.slverr & st_q.rdy;
  assign txOut.txPending = |cand;
  assign txOut.txActive  = st_q.txState == TX_ACTIVE;
  assign txOut.txSel     = st_q.txSel;
  assign txOut.txImage   = st_q.txImg;
  assign errPassive  = st_q.flags[FLG_RXP] | st_q.flags[FLG_TXP];
  assign busOffState = busOff;

  // request lines stay up while any unmasked flag is set
  assign irq.wake = st_q.flags[FLG_WAKE] & st_q.rxIe[FLG_WAKE];
  assign irq.err  = |(st_q.flags[ERR_HI:ERR_LO]
                      & st_q.rxIe[ERR_HI:ERR_LO]);
  assign irq.rx   = st_q.flags[FLG_RXF] & st_q.rxIe[FLG_RXF];
  assign irq.tx   = |(st_q.txEmpty & st_q.txIe);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // helper: no candidate ranks strictly below the pick
  always_comb begin
    rankOk = cand[sIdx];
    for (int i = 0; i < NBUF; i++) begin
      if (cand[i] && st_q.rank[i] < st_q.rank[sIdx]) begin
        rankOk = 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_txdone;
    (st_q.txState == TX_ACTIVE && engEvt.txDone) |=>
      st_q.txEmpty[$past(st_q.txSel)] && !st_q.abortAck[$past(st_q.txSel)];
  endproperty
  a_txdone: assert property (p_txdone) else $error("sent buffer not freed");

  property p_lowest;
    sFound |-> rankOk;
  endproperty
  a_lowest: assert property (p_lowest) else $error("rank pick wrong");

  property p_retry;
    (st_q.txState == TX_ACTIVE && engEvt.txFail && !engEvt.txDone)
      |=> st_q.txState == TX_IDLE;
  endproperty
  a_retry: assert property (p_retry) else $error("no reselect");

  property p_abort;
    (grant != '0) |=> (st_q.abortAck & st_q.txEmpty & $past(grant))
                      == $past(grant);
  endproperty
  a_abort: assert property (p_abort) else $error("abort not acked");

  property p_closed;
    st_q.mode == FM_CLOSED |-> !fHit && !direct && !toBg;
  endproperty
  a_closed: assert property (p_closed) else $error("closed accepts");

  property p_rxfull;
    direct |=> st_q.flags[FLG_RXF] && st_q.hit == $past(fIdx);
  endproperty
  a_rxfull: assert property (p_rxfull) else $error("rx full not set");

  property p_warn;
    st_q.rec >= RWARN |=> st_q.flags[FLG_RXW];
  endproperty
  a_warn: assert property (p_warn) else $error("rx warning missing");

  property p_boff;
    st_q.tec > TBOFF |-> !txOut.txPending ##1 st_q.flags[FLG_BOFF];
  endproperty
  a_boff: assert property (p_boff) else $error("bus-off missing");

  property p_ovr;
    (accepted && st_q.flags[FLG_RXF] && st_q.bgPend && !copyBg)
      |=> st_q.flags[FLG_OVR] && st_q.bgPend;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun missing");

  property p_hold;
    (clrF[FLG_TXW] && st_q.tec >= TWARN) |=> st_q.flags[FLG_TXW];
  endproperty
  a_hold: assert property (p_hold) else $error("flag cleared early");

  c_sent: cover property (st_q.txState == TX_ACTIVE && engEvt.txDone);
  c_abort: cover property (grant != '0);
  c_ovr: cover property (ovrEvt);
  c_bg: cover property (toBg ##[1:20] copyBg);
endmodule

// [sim/can_engine_model.sv]
// far-side can engine model: arbitration, frame results, rx pin
`timescale 1ns/1ps
module can_engine_model
  import can_pkg::*;
(
  input  wire logic         clk,
  output can_pkg::eng_evt_s ev,
  output logic              rxPin
);
  import can_pkg::*;
  // bus idles recessive, no event pending
  initial begin
    ev = '0;
    rxPin = 1'b1;
  end
  // one-cycle event; id is inverted after so stale data never matches
  task automatic pulse(input logic [5:0] k, input logic [31:0] id);
    eng_evt_s e;
    e = {k, id, {IMG_W{1'b0}}};
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= {6'h00, ~id, {IMG_W{1'b1}}};
    #1;
  endtask
  // level on the receive line, 0 is dominant
  task automatic bus(input logic lvl);
    @(posedge clk);
    rxPin <= lvl;
  endtask
endmodule

// [sim/can_tx_sched_filter_irq_bench.sv]
// self-checking bench for tx scheduling, filter and flag logic
`timescale 1ns/1ps
module can_tx_sched_filter_irq_bench;
  import can_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        sleepAck = 1'b0;
  logic        rxPin;
  logic        errPassive;
  logic        busOffState;
  logic        err;
  logic [31:0] rd;
  apb_req_s    apbReq = '0;
  apb_rsp_s    apbRsp;
  eng_evt_s    engEvt;
  tx_out_s     txOut;
  irq_s        irq;
  int          miscompares = 0;
  int          compares = 0;
  int          tec = 0;
  logic [31:0] pat [4] = '{32'h11223344, 32'h99881122, 32'h77333300,
                           32'h55555555};
  logic [31:0] ids [4] = '{32'h11223344, 32'h1122abcd, 32'h33abcdef,
                           32'h55555555};
  logic [31:0] hit [4] = '{32'h0, 32'h1, 32'h1, 32'h1};
  filt_mode_e  md [4] = '{FM_SINGLE, FM_DUAL, FM_QUAD, FM_CLOSED};

  // 125 MHz clock
  always #4 clk = ~clk;

  can_tx_sched_filter_irq uut (
    .clk(clk), .reset(reset), .apbReq(apbReq), .apbRsp(apbRsp),
    .engEvt(engEvt), .rxPin(rxPin), .sleepAck(sleepAck),
    .txOut(txOut), .irq(irq), .errPassive(errPassive),
    .busOffState(busOffState)
  );
  can_engine_model eng (.clk(clk), .ev(engEvt), .rxPin(rxPin));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apbReq <= '{1'b1, 1'b1, w, a, d};
    // no own limit: a hang is ended by the watchdog
    do begin
      @(posedge clk);
    end while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '{1'b0, 1'b0, w, a, d};
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // one arbitration attempt lost to an error
  task automatic fail();
    eng.pulse(6'h20, 32'h0);
    eng.pulse(6'h08, 32'h0);
    tec += 8;
  endtask
  task automatic conclude();
    if (miscompares == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog, well past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rdc(TXFLG_OFS, 32'h7, 32'h77);
    rdc(RXFLG_OFS, 32'h0, 32'hff);
    apb(1'b0, 12'h0fc, 32'h0);
    chk(32'(err), 32'h1);
    for (int b = 0; b < 3; b++) begin
      wr(TXB_BASE + 12'(16 * b + 12), ALL_ONES);
      rdc(TXB_BASE + 12'(16 * b + 12), LAST_MASK, ALL_ONES);
    end
    // rank order, reselection after an error, abort
    wr(RANK_OFS, 32'h0020_1030);
    wr(TXCTL_OFS, 32'h70);
    chk(32'(irq.tx), 32'h1);
    wr(TXFLG_OFS, 32'h7);
    chk(32'(irq.tx), 32'h0);
    eng.pulse(6'h20, 32'h0);
    chk(32'(txOut.txSel), 32'h1);
    chk(32'(txOut.txActive), 32'h1);
    chk(32'(txOut.txImage[IMG_W-1 -: BYTE_W]), 32'hff);
    fail();
    wr(RANK_OFS, 32'h0020_4030);
    eng.pulse(6'h20, 32'h0);
    chk(32'(txOut.txSel), 32'h2);
    eng.pulse(6'h10, 32'h0);
    tec -= 1;
    rdc(TXFLG_OFS, 32'h4, 32'h77);
    chk(32'(irq.tx), 32'h1);
    wr(TXCTL_OFS, 32'h71);
    rdc(TXFLG_OFS, 32'h15, 32'h77);
    eng.pulse(6'h20, 32'h0);
    chk(32'(txOut.txSel), 32'h1);
    eng.pulse(6'h10, 32'h0);
    tec -= 1;
    rdc(TXFLG_OFS, 32'h17, 32'h77);
    // each filter mode, quad with two hits reports the lower
    wr(MSK_OFS, 32'h0);
    wr(RXIE_OFS, 32'h03);
    for (int i = 0; i < 4; i++) begin
      wr(CTRL_OFS, 32'(md[i]));
      wr(PAT_OFS, pat[i]);
      eng.pulse(6'h04, ids[i]);
      rdc(RXFLG_OFS, 32'(i < 3), 32'h1);
      rdc(HIT_OFS, hit[i], 32'h3);
      chk(32'(irq.rx), 32'(i < 3));
      wr(RXFLG_OFS, 32'h1);
    end
    // two held frames, third overruns, background drains on clear
    wr(CTRL_OFS, 32'h0);
    wr(PAT_OFS, 32'h11223344);
    repeat (3) eng.pulse(6'h04, 32'h11223344);
    rdc(RXFLG_OFS, 32'h3, 32'h3);
    chk(32'(irq.err), 32'h1);
    wr(RXFLG_OFS, 32'h3);
    rdc(RXFLG_OFS, 32'h1, 32'h3);
    chk(32'(irq.err), 32'h0);
    wr(RXFLG_OFS, 32'h1);
    // error thresholds on the transmit counter
    wr(TXFLG_OFS, 32'h1);
    wr(RXIE_OFS, 32'h2f);
    while (tec < 96) fail();
    rdc(ERRC_OFS, 32'(tec) << 8, 32'h1ff00);
    rdc(RXFLG_OFS, 32'h20, 32'h2c);
    wr(RXFLG_OFS, 32'h20);
    rdc(RXFLG_OFS, 32'h20, 32'h20);
    chk(32'(irq.err), 32'h1);
    while (tec <= 127) fail();
    rdc(RXFLG_OFS, 32'h28, 32'h2c);
    chk(32'(errPassive), 32'h1);
    while (tec <= 255) fail();
    rdc(RXFLG_OFS, 32'h2c, 32'h2c);
    chk(32'(busOffState), 32'h1);
    chk(32'(txOut.txPending), 32'h0);
    eng.pulse(6'h01, 32'h0);
    chk(32'(busOffState), 32'h0);
    // wakeup needs sleep ack and enable together
    wr(RXIE_OFS, 32'h0);
    @(posedge clk);
    sleepAck <= 1'b1;
    eng.bus(1'b0);
    repeat (4) @(posedge clk);
    rdc(RXFLG_OFS, 32'h0, 32'h80);
    wr(RXIE_OFS, 32'h80);
    rdc(RXFLG_OFS, 32'h80, 32'h80);
    chk(32'(irq.wake), 32'h1);
    eng.bus(1'b1);
    @(posedge clk);
    sleepAck <= 1'b0;
    repeat (4) @(posedge clk);
    wr(RXFLG_OFS, 32'h80);
    rdc(RXFLG_OFS, 32'h0, 32'h80);
    conclude();
  end
endmodule
